// >>> hdl/asf_pkg.sv
package asf_pkg;
	// flag register layout
	localparam logic [11:0] ASF_FLAG_REG_ADDR = 12'hfd8;
	localparam int ASF_BIT_CARRY = 0;
	localparam int ASF_BIT_DCARRY = 1;
	localparam int ASF_BIT_ZERO = 2;
	localparam int ASF_BIT_OVF = 3;
	localparam int ASF_BIT_NEG = 4;
	localparam logic [7:0] ASF_FLAG_MASK = 8'h1f;
	localparam logic [4:0] ASF_FLAG_RESET = 5'h00;
	localparam int ASF_PC_TEST_BIT = 21;
	localparam logic [21:0] ASF_PC_RESET = 22'h000000;

	// alu operations driven by the core
	typedef enum logic [3:0]
	{
		ASF_OP_NONE = 4'h0,
		ASF_OP_ADD = 4'h1,
		ASF_OP_ADDC = 4'h2,
		ASF_OP_SUB = 4'h3,
		ASF_OP_SUBB = 4'h4,
		ASF_OP_LOGIC = 4'h5,
		ASF_OP_CLEAR = 4'h6,
		ASF_OP_NOFLAG = 4'h7
	} asf_op_t;

	// data memory addressing modes
	typedef enum logic [2:0]
	{
		ASF_AM_INHERENT = 3'h0,
		ASF_AM_LITERAL = 3'h1,
		ASF_AM_DIRECT = 3'h3,
		ASF_AM_INDIRECT = 3'h2,
		ASF_AM_INDEXED = 3'h6
	} asf_amode_t;

	typedef struct packed
	{
		logic negative_flag;
		logic overflow_flag;
		logic zero_flag;
		logic digit_carry_flag;
		logic carry_flag;
	} asf_flags_t;

	typedef struct packed
	{
		asf_flags_t flags;
		logic [21:0] instruction_pointer;
		logic [7:0] result;
	} asf_state_t;
endpackage : asf_pkg

// >>> hdl/asf_status_flags.sv
// Behaviour
// RULE1 - flag-writing ops cannot write flag bits
// RULE2 - clearing flag register sets only zero
// RULE3 - bit, swap, move ops keep flags
// RULE4 - carry means no borrow in subtraction
// RULE5 - small variant bits read zero
// RULE6 - pointer bit 21 only in test modes
// RULE7 - program via pointer, data four modes
// RULE8 - mode fixed, or up to three selectable
// RULE9 - indexed offset mode needs extended set
// RULE10 - flags follow result per arithmetic rules
// RULE11 - top three bits zero, low five writable
module asf_status_flags
	import asf_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic clockEnable,
	input wire asf_op_t aluOp,
	input wire logic [7:0] operandA,
	input wire logic [7:0] operandB,
	input wire logic writeEnable,
	input wire logic [11:0] writeAddr,
	input wire logic [7:0] writeData,
	input wire logic [7:0] flagOverride,
	input wire logic largePackage,
	input wire logic testMode,
	input wire logic extended_set_select,
	input wire logic pointerLoad,
	input wire logic [21:0] pointerValue,
	input wire logic pointerStep,
	input wire asf_amode_t requestedMode,
	input wire logic [1:0] modeCount,
	output logic [7:0] flagRegRead,
	output logic [7:0] aluResult,
	output logic [21:0] programAddr,
	output asf_amode_t activeMode,
	output logic modeIllegal
);
	asf_state_t state_r;
	asf_state_t state_nxt;
	logic [8:0] sum;
	logic [4:0] lowSum;
	// adder inputs after the subtract inversion
	logic [7:0] bOp;
	logic cin;
	logic flagWrite;

	// adder taps kept as named nets so the flag logic reads like the rules
	logic carryOut;
	logic digitCarryOut;
	logic signedOverflow;
	logic resultZero;
	logic resultNegative;
	logic [7:0] logicResult;
	logic flagsOwnedByAlu;
	logic [21:0] pointerVisible;

	// subtraction adds the inverted operand, so carry reads as not-borrow
	always_comb
	begin
		bOp = operandB;
		cin = 1'b0;
		case (aluOp)
			ASF_OP_ADDC: cin = state_r.flags.carry_flag;
			ASF_OP_SUB:
			begin
				bOp = ~operandB; // [RULE4]
				cin = 1'b1;
			end
			ASF_OP_SUBB:
			begin
				bOp = ~operandB; // [RULE4]
				cin = state_r.flags.carry_flag;
			end
			ASF_OP_ADD: cin = 1'b0;
			default: cin = 1'b0;
		endcase
		sum = {1'b0, operandA} + {1'b0, bOp} + {8'h00, cin};
		// the low nibble is summed again for the digit carry
		lowSum = {1'b0, operandA[3:0]} + {1'b0, bOp[3:0]} + {4'h0, cin};
		// carry out of bit 7 and bit 3; under subtraction a one means no borrow
		carryOut = sum[8]; // [RULE4]
		digitCarryOut = lowSum[4]; // [RULE4]
		// signed overflow: both inputs share a sign that the result lost
		signedOverflow = (operandA[7] == bOp[7]) && (sum[7] != operandA[7]);
		resultZero = (sum[7:0] == 8'h00);
		resultNegative = sum[7];
		logicResult = operandA & operandB;
	end

	assign flagWrite = writeEnable && (writeAddr == ASF_FLAG_REG_ADDR);

	// ops that compute flags own all five bits this cycle; a register write loses
	always_comb
	begin
		case (aluOp)
			ASF_OP_NONE, ASF_OP_NOFLAG: flagsOwnedByAlu = 1'b0; // [RULE3]
			default: flagsOwnedByAlu = 1'b1; // [RULE1]
		endcase
	end

	// one next-state process for flags, result and pointer
	always_comb
	begin
		state_nxt = state_r;
		// plain register write, only while no op owns the flags
		if (flagWrite && !flagsOwnedByAlu) // [RULE1] [RULE3]
		begin
			state_nxt.flags = asf_flags_t'(writeData[4:0] & ASF_FLAG_MASK[4:0]); // [RULE11]
		end

		// hardware wins: under a flag-owning op the flag bits follow the alu, never the write data
		case (aluOp)
			// add and subtract move all five flags
			ASF_OP_ADD, ASF_OP_ADDC, ASF_OP_SUB, ASF_OP_SUBB:
			begin
				state_nxt.result = sum[7:0];
				state_nxt.flags.carry_flag = carryOut; // [RULE10] [RULE1]
				state_nxt.flags.digit_carry_flag = digitCarryOut; // [RULE10]
				state_nxt.flags.zero_flag = resultZero; // [RULE10]
				state_nxt.flags.negative_flag = resultNegative; // [RULE10]
				state_nxt.flags.overflow_flag = signedOverflow; // [RULE10]
			end
			// logic moves zero and negative; carry, digit carry and overflow hold
			ASF_OP_LOGIC:
			begin
				state_nxt.result = logicResult;
				state_nxt.flags.zero_flag = (logicResult == 8'h00); // [RULE1]
				state_nxt.flags.negative_flag = logicResult[7];
			end
			// clearing the flag register still only raises zero
			ASF_OP_CLEAR:
			begin
				state_nxt.result = 8'h00;
				state_nxt.flags.zero_flag = 1'b1; // [RULE2]
			end
			// moves, swaps and bit ops carry data but never touch a flag
			ASF_OP_NOFLAG: state_nxt.result = flagOverride; // [RULE3]
			default: state_nxt.result = state_r.result;
		endcase

		// program memory is reached only through the pointer; load beats step
		if (pointerLoad)
		begin
			state_nxt.instruction_pointer = pointerValue; // [RULE7]
		end
		else if (pointerStep)
		begin
			state_nxt.instruction_pointer = state_r.instruction_pointer + 22'h000001;
		end

		// bit 21 exists only in test mode, so it never survives outside it
		if (!testMode)
		begin
			state_nxt.instruction_pointer[ASF_PC_TEST_BIT] = 1'b0; // [RULE6]
		end

		// the variant strap hides only registers outside this block
		if (!largePackage)
		begin
			state_nxt.result = state_nxt.result; // variant only hides extra registers
		end
	end

	// flags have no defined power-on value; reset picks zero
	// clock enable low freezes every bit of state, flags included
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_r <= '{flags: asf_flags_t'(ASF_FLAG_RESET), instruction_pointer: ASF_PC_RESET,
				result: 8'h00};
		end
		else if (clockEnable)
		begin
			state_r <= state_nxt;
		end
	end

	// addressing mode check
	always_comb
	begin
		activeMode = requestedMode;
		modeIllegal = 1'b0;
		case (requestedMode)
			ASF_AM_INHERENT, ASF_AM_LITERAL, ASF_AM_DIRECT, ASF_AM_INDIRECT: modeIllegal = 1'b0; // [RULE7]
			ASF_AM_INDEXED:
			begin
				// without the extended set the offset mode does not exist; fall back to direct
				if (!extended_set_select)
				begin
					activeMode = ASF_AM_DIRECT; // [RULE9]
					modeIllegal = 1'b1;
				end
			end
			// unused codes decode as inherent and are refused
			default:
			begin
				activeMode = ASF_AM_INHERENT;
				modeIllegal = 1'b1;
			end
		endcase

		// an instruction must offer at least one mode
		if (modeCount == 2'h0)
		begin
			modeIllegal = 1'b1; // [RULE8]
		end
	end

	// top three flag bits are not built and always read zero
	assign flagRegRead = {3'h0, state_r.flags}; // [RULE11] [RULE5]
	assign aluResult = state_r.result;

	// mask repeated on the output so a late drop of test mode hides bit 21 at once
	always_comb
	begin
		pointerVisible = state_r.instruction_pointer;
		if (!testMode)
		begin
			pointerVisible[ASF_PC_TEST_BIT] = 1'b0; // [RULE6]
		end
	end
	assign programAddr = pointerVisible;
endmodule : asf_status_flags

// >>> tb/asf_status_flags_properties.sv
module asf_status_flags_properties
	import asf_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic clockEnable,
	input wire asf_op_t aluOp,
	input wire logic [7:0] operandA,
	input wire logic [7:0] operandB,
	input wire logic writeEnable,
	input wire logic [7:0] flagRegRead,
	input wire logic [7:0] aluResult,
	input wire logic testMode,
	input wire logic extended_set_select,
	input wire asf_amode_t requestedMode,
	input wire asf_amode_t activeMode,
	input wire logic modeIllegal,
	input wire logic [21:0] programAddr
);
	// a frozen core updates nothing, so those cycles are not judged
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_b || !clockEnable);
	a_top_zero: assert property (flagRegRead[7:5] == 3'h0) else $error("top bits");
	a_sub_equal: assert property (aluOp == ASF_OP_SUB && operandA == operandB |=>
		flagRegRead == 8'h07) else $error("sub equal");
	a_sub_less: assert property (aluOp == ASF_OP_SUB && operandA < operandB |=>
		!flagRegRead[ASF_BIT_CARRY]) else $error("sub borrow");
	a_add_sum: assert property (aluOp == ASF_OP_ADD |=>
		aluResult == $past(operandA) + $past(operandB)) else $error("add sum");
	a_add_zero: assert property (aluOp == ASF_OP_ADD |=>
		flagRegRead[ASF_BIT_ZERO] == (aluResult == 8'h00)) else $error("add zero");
	a_add_neg: assert property (aluOp == ASF_OP_ADD |=>
		flagRegRead[ASF_BIT_NEG] == aluResult[7]) else $error("add negative");
	a_clear_zero: assert property (aluOp == ASF_OP_CLEAR |=>
		flagRegRead == ($past(flagRegRead) | 8'h04)) else $error("clear");
	a_noflag_keep: assert property (aluOp == ASF_OP_NOFLAG && !writeEnable |=>
		$stable(flagRegRead)) else $error("noflag");
	a_logic_keep: assert property (aluOp == ASF_OP_LOGIC |=>
		(flagRegRead & 8'h0b) == ($past(flagRegRead) & 8'h0b)) else $error("logic keep");
	a_pointer_hidden: assert property (!testMode |->
		!programAddr[ASF_PC_TEST_BIT]) else $error("pointer bit");
	a_indexed_gated: assert property (!extended_set_select &&
		requestedMode == ASF_AM_INDEXED |-> modeIllegal && activeMode == ASF_AM_DIRECT)
		else $error("indexed gate");
endmodule : asf_status_flags_properties

// >>> tb/asf_status_flags_tb.sv
module asf_status_flags_tb
	import asf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0, rst_b = 1'b0, clockEnable = 1'b1, writeEnable = 1'b0;
	logic largePackage = 1'b1, testMode = 1'b0, pointerLoad = 1'b0;
	logic pointerStep = 1'b0, extended_set_select = 1'b0, modeIllegal;
	logic [7:0] operandA = 8'h00, operandB = 8'h00, writeData = 8'h00;
	logic [7:0] flagOverride = 8'h5a, flagRegRead, aluResult;
	logic [11:0] writeAddr = ASF_FLAG_REG_ADDR;
	logic [21:0] pointerValue = 22'h3fffff, programAddr;
	logic [1:0] modeCount = 2'h1;
	asf_op_t aluOp = ASF_OP_NONE;
	asf_amode_t requestedMode = ASF_AM_INDEXED, activeMode;
	int n_fail = 0, n_compared = 0;
	asf_status_flags u_dut
	(
		.clock(clock),
		.rst_b(rst_b),
		.clockEnable(clockEnable),
		.aluOp(aluOp),
		.operandA(operandA),
		.operandB(operandB),
		.writeEnable(writeEnable),
		.writeAddr(writeAddr),
		.writeData(writeData),
		.flagOverride(flagOverride),
		.largePackage(largePackage),
		.testMode(testMode),
		.extended_set_select(extended_set_select),
		.pointerLoad(pointerLoad),
		.pointerValue(pointerValue),
		.pointerStep(pointerStep),
		.requestedMode(requestedMode),
		.modeCount(modeCount),
		.flagRegRead(flagRegRead),
		.aluResult(aluResult),
		.programAddr(programAddr),
		.activeMode(activeMode),
		.modeIllegal(modeIllegal)
	);
	// 100 MHz core clock
	always #5 clock = ~clock;
	// count every compare, report a miss at once
	task automatic check(input string n, input logic [21:0] s, input logic [21:0] e);
		n_compared++;
		if (s !== e)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : check
	// one op beside an optional flag write; idle after it so the read back is stable
	task automatic op(input asf_op_t o, input logic [15:0] ab, input logic [8:0] w, input logic [7:0] e);
		aluOp <= o;
		{operandA, operandB} <= ab;
		{writeEnable, writeData} <= w;
		@(posedge clock);
		aluOp <= ASF_OP_NONE;
		writeEnable <= 1'b0;
		@(posedge clock);
		check("flags", flagRegRead, e);
	endtask : op
	// verdict and end of run
	task automatic results();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : results
	// reset, then flag tests, then pointer and mode
	initial
	begin
		repeat (8) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		check("reset", flagRegRead, 22'h0);
		check("fallback", activeMode, ASF_AM_DIRECT);
		check("refused", modeIllegal, 1'b1);
		op(ASF_OP_NOFLAG, 16'h0, 9'h1ea, 8'h0a);
		check("move", aluResult, 22'h5a);
		op(ASF_OP_CLEAR, 16'h0, 9'h100, 8'h0e);
		op(ASF_OP_NOFLAG, 16'h0, 9'h0ff, 8'h0e);
		op(ASF_OP_ADD, 16'h7f01, 9'h100, 8'h1a);
		check("sum", aluResult, 22'h80);
		op(ASF_OP_SUB, 16'h0505, 9'h0, 8'h07);
		op(ASF_OP_SUB, 16'h0305, 9'h0, 8'h10);
		op(ASF_OP_ADD, 16'hff01, 9'h0, 8'h07);
		op(ASF_OP_ADDC, 16'h0101, 9'h0, 8'h00);
		check("carry in", aluResult, 22'h03);
		op(ASF_OP_SUBB, 16'h0503, 9'h0, 8'h03);
		check("borrow in", aluResult, 22'h01);
		op(ASF_OP_LOGIC, 16'hf00f, 9'h100, 8'h07);
		op(ASF_OP_LOGIC, 16'h80ff, 9'h0, 8'h13);
		check("and", aluResult, 22'h80);
		clockEnable <= 1'b0;
		op(ASF_OP_CLEAR, 16'h0, 9'h1ff, 8'h13);
		clockEnable <= 1'b1;
		largePackage <= 1'b0;
		op(ASF_OP_NOFLAG, 16'h0, 9'h1ff, 8'h1f);
		$display("flag test done");
		rst_b <= 1'b0;
		@(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		check("second reset", flagRegRead, 22'h0);
		check("reset result", aluResult, 22'h0);
		pointerLoad <= 1'b1;
		@(posedge clock);
		pointerLoad <= 1'b0;
		pointerStep <= 1'b1;
		@(posedge clock);
		check("pointer", programAddr, 22'h1fffff);
		pointerStep <= 1'b0;
		@(posedge clock);
		check("step", programAddr, 22'h0);
		testMode <= 1'b1;
		pointerLoad <= 1'b1;
		modeCount <= 2'h0;
		requestedMode <= ASF_AM_DIRECT;
		@(posedge clock);
		pointerLoad <= 1'b0;
		check("no modes", modeIllegal, 1'b1);
		check("direct", activeMode, ASF_AM_DIRECT);
		modeCount <= 2'h3;
		requestedMode <= ASF_AM_INDEXED;
		extended_set_select <= 1'b1;
		@(posedge clock);
		check("test pointer", programAddr, 22'h3fffff);
		check("mode", activeMode, ASF_AM_INDEXED);
		check("allowed", modeIllegal, 1'b0);
		$display("pointer test done");
		results();
	end
	// cut a hang short; the tests need under 100 cycles
	initial
	begin
		repeat (400) @(posedge clock);
		n_fail++;
		results();
	end
endmodule : asf_status_flags_tb
bind asf_status_flags asf_status_flags_properties u_chk
(
	.clock(clock),
	.rst_b(rst_b),
	.clockEnable(clockEnable),
	.aluOp(aluOp),
	.operandA(operandA),
	.operandB(operandB),
	.writeEnable(writeEnable),
	.flagRegRead(flagRegRead),
	.aluResult(aluResult),
	.testMode(testMode),
	.extended_set_select(extended_set_select),
	.requestedMode(requestedMode),
	.activeMode(activeMode),
	.modeIllegal(modeIllegal),
	.programAddr(programAddr)
);
